//--- pbsc_consts.svh
/*
  Constants of the pipelined burst SRAM cycle control: widths, reset
  values and cycle counts.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef PBSC_CONSTS_SVH
`define PBSC_CONSTS_SVH

// array geometry
`define PBSC_ADDR_W 20
`define PBSC_LANES 4
`define PBSC_BYTE_W 8

// low address bits stepped by the burst counter
`define PBSC_BURST_W 2

// sleep entry and recovery, in clock periods
`define PBSC_SLEEP_ENTRY_CYC 2
`define PBSC_SLEEP_RECOVERY_CYC 2

// reset values
`define PBSC_ORDER_RST 1'b1
`define PBSC_ADDR_RST 'h0
`define PBSC_CNT_RST 2'h0

`endif

//--- pbsc_pkg.sv
/*
  Types of the pipelined burst SRAM cycle control.
  Assumes pbsc_consts.svh sits in the same folder.
*/
`include "pbsc_consts.svh"

package pbsc_pkg;

  // burst kind latched at a load edge; gray along idle, read, write
  typedef enum logic [1:0] {
    BURST_IDLE  = 2'h0,
    BURST_READ  = 2'h1,
    BURST_WRITE = 2'h3
  } pbsc_burst_type;

endpackage

//--- pbsc_mem.sv
/*
  Word memory of the burst SRAM with per-lane write enables and a
  registered read port.
  Assumes one clock; read and write of the same word in one cycle
  returns the old word.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pbsc_consts.svh"

module pbsc_mem #(
  parameter int AW = `PBSC_ADDR_W,
  parameter int LANES = `PBSC_LANES,
  parameter int BYTE_W = `PBSC_BYTE_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic rdEn,
  input wire logic [AW-1:0] rdAddr,
  output logic [LANES*(BYTE_W+1)-1:0] rdData,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [LANES*(BYTE_W+1)-1:0] wrData,
  input wire logic [LANES-1:0] wrMask
);
  localparam int DATA_W = LANES * BYTE_W;
  localparam int WORD_W = DATA_W + LANES;

  logic [WORD_W-1:0] array [0:(1<<AW)-1];
  logic [WORD_W-1:0] rdData_ff;
  logic [WORD_W-1:0] nxt_rdData;

  always_comb begin
    nxt_rdData = rdData_ff;
    if (rdEn) begin
      nxt_rdData = array[rdAddr];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= '0;
    end else if (clkEn) begin
      rdData_ff <= nxt_rdData;
    end
  end

  // each lane writes its data byte and its parity bit only
  always_ff @(posedge sys_clk) begin
    if (clkEn && wrEn) begin
      for (int i = 0; i < LANES; i++) begin
        if (wrMask[i]) begin
          array[wrAddr][i*BYTE_W +: BYTE_W] <= wrData[i*BYTE_W +: BYTE_W];
          array[wrAddr][DATA_W+i] <= wrData[DATA_W+i];
        end
      end
    end
  end

  assign rdData = rdData_ff;

endmodule // pbsc_mem

`default_nettype wire

//--- pbsc_skid.sv
/*
  Two-entry write buffer between write data capture and the memory,
  with a lookup that merges pending lanes for a read of the same word.
  Assumes one clock; a push while full is refused (inReady low).
*/
`timescale 1ns/1ps
`default_nettype none
`include "pbsc_consts.svh"

module pbsc_skid #(
  parameter int AW = `PBSC_ADDR_W,
  parameter int LANES = `PBSC_LANES,
  parameter int BYTE_W = `PBSC_BYTE_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [AW-1:0] inAddr,
  input wire logic [LANES*(BYTE_W+1)-1:0] inData,
  input wire logic [LANES-1:0] inMask,
  output logic outValid,
  input wire logic outReady,
  output logic [AW-1:0] outAddr,
  output logic [LANES*(BYTE_W+1)-1:0] outData,
  output logic [LANES-1:0] outMask,
  input wire logic [AW-1:0] lookAddr,
  output logic [LANES-1:0] hitMask,
  output logic [LANES*(BYTE_W+1)-1:0] hitData
);
  localparam int DATA_W = LANES * BYTE_W;
  localparam int WORD_W = DATA_W + LANES;

  function automatic logic [WORD_W-1:0] laneMerge(
    input logic [WORD_W-1:0] base,
    input logic [WORD_W-1:0] over,
    input logic [LANES-1:0] mask
  );
    logic [WORD_W-1:0] r;
    r = base;
    for (int i = 0; i < LANES; i++) begin
      if (mask[i]) begin
        r[i*BYTE_W +: BYTE_W] = over[i*BYTE_W +: BYTE_W];
        r[DATA_W+i] = over[DATA_W+i];
      end
    end
    return r;
  endfunction

  logic [AW-1:0] eAddr_ff [2];
  logic [AW-1:0] nxt_eAddr [2];
  logic [WORD_W-1:0] eData_ff [2];
  logic [WORD_W-1:0] nxt_eData [2];
  logic [LANES-1:0] eMask_ff [2];
  logic [LANES-1:0] nxt_eMask [2];
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic head_ff;
  logic nxt_head;
  logic push;
  logic pop;
  logic tail;

  always_comb begin
    nxt_eAddr = eAddr_ff;
    nxt_eData = eData_ff;
    nxt_eMask = eMask_ff;
    push = inValid && !cnt_ff[1];
    pop = (cnt_ff != 2'h0) && outReady;
    tail = head_ff ^ cnt_ff[0];
    if (push) begin
      nxt_eAddr[tail] = inAddr;
      nxt_eData[tail] = inData;
      nxt_eMask[tail] = inMask;
    end
    nxt_head = pop ? ~head_ff : head_ff;
    nxt_cnt = 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) begin
        eAddr_ff[i] <= '0;
        eData_ff[i] <= '0;
        eMask_ff[i] <= '0;
      end
      cnt_ff <= 2'h0;
      head_ff <= 1'b0;
    end else if (clkEn) begin
      eAddr_ff <= nxt_eAddr;
      eData_ff <= nxt_eData;
      eMask_ff <= nxt_eMask;
      cnt_ff <= nxt_cnt;
      head_ff <= nxt_head;
    end
  end

  // oldest first, so the newest write to a lane wins
  always_comb begin
    hitMask = '0;
    hitData = '0;
    if (cnt_ff != 2'h0 && eAddr_ff[head_ff] == lookAddr) begin
      hitData = laneMerge(hitData, eData_ff[head_ff], eMask_ff[head_ff]);
      hitMask = hitMask | eMask_ff[head_ff];
    end
    if (cnt_ff[1] && eAddr_ff[~head_ff] == lookAddr) begin
      hitData = laneMerge(hitData, eData_ff[~head_ff], eMask_ff[~head_ff]);
      hitMask = hitMask | eMask_ff[~head_ff];
    end
    if (push && inAddr == lookAddr) begin
      hitData = laneMerge(hitData, inData, inMask);
      hitMask = hitMask | inMask;
    end
  end

  assign inReady = ~cnt_ff[1];
  assign outValid = cnt_ff != 2'h0;
  assign outAddr = eAddr_ff[head_ff];
  assign outData = eData_ff[head_ff];
  assign outMask = eMask_ff[head_ff];

endmodule // pbsc_skid

`default_nettype wire

//--- pbsc_top.sv
/*
  Cycle control of a synchronous pipelined burst SRAM: load and advance
  decoding, two-bit burst sequencing, read pipeline, delayed write data
  with byte lanes, sleep and output tristate control.
  Assumes the memory controller drives address, control and data from
  sys_clk; sleep, burst order and output enable are asynchronous pins.

*/
`timescale 1ns/1ps
`default_nettype none
`include "pbsc_consts.svh"

module pbsc_top #(
  parameter int ADDR_W = `PBSC_ADDR_W,
  parameter int LANES = `PBSC_LANES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic clock_qualify_n,
  input wire logic advance_or_load,
  input wire logic writeEnableN,
  input wire logic chip_select_1_n,
  input wire logic chip_select_2,
  input wire logic chip_select_3_n,
  input wire logic [LANES-1:0] byte_lane_write_n,
  input wire logic [ADDR_W-1:0] addrIn,
  input wire logic burstOrder,
  input wire logic sleep_request,
  input wire logic outputEnableN,
  input wire logic [LANES*`PBSC_BYTE_W-1:0] dqIn,
  output logic [LANES*`PBSC_BYTE_W-1:0] dqOut,
  output logic dqOe,
  input wire logic [LANES-1:0] parity_lines_in,
  output logic [LANES-1:0] parity_lines_out,
  output logic parity_lines_oe,
  output logic writeQueueReady,
  output logic sleepState
);
  localparam int BYTE_W = `PBSC_BYTE_W;
  localparam int DATA_W = LANES * BYTE_W;
  localparam int WORD_W = DATA_W + LANES;
  localparam int BW = `PBSC_BURST_W;
  localparam int SLP_N = `PBSC_SLEEP_ENTRY_CYC;

  function automatic logic [WORD_W-1:0] laneMerge(
    input logic [WORD_W-1:0] base,
    input logic [WORD_W-1:0] over,
    input logic [LANES-1:0] mask
  );
    logic [WORD_W-1:0] r;
    r = base;
    for (int i = 0; i < LANES; i++) begin
      if (mask[i]) begin
        r[i*BYTE_W +: BYTE_W] = over[i*BYTE_W +: BYTE_W];
        r[DATA_W+i] = over[DATA_W+i];
      end
    end
    return r;
  endfunction

  // next low address bits of a burst beat
  function automatic logic [BW-1:0] burstNext(
    input logic [BW-1:0] cur,
    input logic [BW-1:0] start,
    input logic [BW-1:0] cnt,
    input logic interleave
  );
    logic [BW-1:0] step;
    step = BW'(cnt + 1'b1);
    if (interleave) begin
      return start ^ step;
    end
    return BW'(cur + 1'b1);
  endfunction

  // asynchronous pin synchronisers
  logic [SLP_N-1:0] sleepSync_ff;
  logic [SLP_N-1:0] nxt_sleepSync;
  logic [1:0] orderSync_ff;
  logic [1:0] nxt_orderSync;
  logic sleepAct;
  logic interleave;

  always_comb begin
    nxt_sleepSync = {sleepSync_ff[SLP_N-2:0], sleep_request};
    nxt_orderSync = {orderSync_ff[0], burstOrder};
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleepSync_ff <= '0;
      orderSync_ff <= {2{`PBSC_ORDER_RST}};
    end else if (clkEn) begin
      sleepSync_ff <= nxt_sleepSync;
      orderSync_ff <= nxt_orderSync;
    end
  end

  assign sleepAct = sleepSync_ff[SLP_N-1];
  assign interleave = orderSync_ff[1];

  // burst state and address
  pbsc_pkg::pbsc_burst_type state_ff;
  pbsc_pkg::pbsc_burst_type nxt_state;
  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] nxt_addr;
  logic [BW-1:0] start_ff;
  logic [BW-1:0] nxt_start;
  logic [BW-1:0] cnt_ff;
  logic [BW-1:0] nxt_cnt;
  logic [ADDR_W-1:0] opAddr;
  logic [LANES-1:0] laneAct;
  logic allSel;
  logic step;
  logic opRead;
  logic opWrite;

  always_comb begin
    allSel = ~chip_select_1_n & chip_select_2 & ~chip_select_3_n;
    laneAct = ~byte_lane_write_n;
    step = ~clock_qualify_n & ~sleepAct;
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_start = start_ff;
    nxt_cnt = cnt_ff;
    opAddr = addr_ff;
    opRead = 1'b0;
    opWrite = 1'b0;
    if (sleepAct) begin
      nxt_state = pbsc_pkg::BURST_IDLE;
    end else if (step) begin
      if (!advance_or_load) begin
        opAddr = addrIn;
        nxt_addr = addrIn;
        nxt_start = addrIn[BW-1:0];
        nxt_cnt = `PBSC_CNT_RST;
        if (!allSel) begin
          nxt_state = pbsc_pkg::BURST_IDLE;
        end else if (writeEnableN) begin
          nxt_state = pbsc_pkg::BURST_READ;
          opRead = 1'b1;
        end else begin
          nxt_state = pbsc_pkg::BURST_WRITE;
          opWrite = |laneAct;
        end
      end else begin
        opAddr = {addr_ff[ADDR_W-1:BW],
          burstNext(addr_ff[BW-1:0], start_ff, cnt_ff, interleave)};
        case (state_ff)
          pbsc_pkg::BURST_IDLE: begin
            nxt_state = pbsc_pkg::BURST_IDLE;
          end
          pbsc_pkg::BURST_READ: begin
            nxt_addr = opAddr;
            nxt_cnt = BW'(cnt_ff + 1'b1);
            opRead = 1'b1;
          end
          pbsc_pkg::BURST_WRITE: begin
            nxt_addr = opAddr;
            nxt_cnt = BW'(cnt_ff + 1'b1);
            opWrite = |laneAct;
          end
          default: begin
            nxt_state = pbsc_pkg::BURST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= pbsc_pkg::BURST_IDLE;
      addr_ff <= ADDR_W'(`PBSC_ADDR_RST);
      start_ff <= `PBSC_CNT_RST;
      cnt_ff <= `PBSC_CNT_RST;
    end else if (clkEn) begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      start_ff <= nxt_start;
      cnt_ff <= nxt_cnt;
    end
  end

  // read pipeline and delayed write data pipeline
  logic rdPend_ff;
  logic nxt_rdPend;
  logic drive_ff;
  logic nxt_drive;
  logic [LANES-1:0] hitMask_ff;
  logic [LANES-1:0] nxt_hitMask;
  logic [WORD_W-1:0] hitData_ff;
  logic [WORD_W-1:0] nxt_hitData;
  logic [WORD_W-1:0] outWord_ff;
  logic [WORD_W-1:0] nxt_outWord;
  logic wp1Valid_ff;
  logic nxt_wp1Valid;
  logic wp2Valid_ff;
  logic nxt_wp2Valid;
  logic [ADDR_W-1:0] wp1Addr_ff;
  logic [ADDR_W-1:0] nxt_wp1Addr;
  logic [ADDR_W-1:0] wp2Addr_ff;
  logic [ADDR_W-1:0] nxt_wp2Addr;
  logic [LANES-1:0] wp1Mask_ff;
  logic [LANES-1:0] nxt_wp1Mask;
  logic [LANES-1:0] wp2Mask_ff;
  logic [LANES-1:0] nxt_wp2Mask;
  logic [WORD_W-1:0] memRdData;
  logic [LANES-1:0] lookMask;
  logic [WORD_W-1:0] lookData;
  logic pushValid;
  logic drainValid;
  logic drainReady;
  logic [ADDR_W-1:0] drainAddr;
  logic [WORD_W-1:0] drainData;
  logic [LANES-1:0] drainMask;

  always_comb begin
    nxt_rdPend = rdPend_ff;
    nxt_drive = drive_ff;
    nxt_hitMask = hitMask_ff;
    nxt_hitData = hitData_ff;
    nxt_outWord = outWord_ff;
    nxt_wp1Valid = wp1Valid_ff;
    nxt_wp2Valid = wp2Valid_ff;
    nxt_wp1Addr = wp1Addr_ff;
    nxt_wp2Addr = wp2Addr_ff;
    nxt_wp1Mask = wp1Mask_ff;
    nxt_wp2Mask = wp2Mask_ff;
    if (sleepAct) begin
      // pending reads and unqueued write data are dropped on sleep entry; queued writes still drain
      nxt_rdPend = 1'b0;
      nxt_drive = 1'b0;
      nxt_wp1Valid = 1'b0;
      nxt_wp2Valid = 1'b0;
    end else if (step) begin
      nxt_rdPend = opRead;
      nxt_hitMask = lookMask;
      nxt_hitData = lookData;
      nxt_drive = rdPend_ff;
      if (rdPend_ff) begin
        nxt_outWord = laneMerge(memRdData, hitData_ff, hitMask_ff);
      end
      nxt_wp1Valid = opWrite;
      nxt_wp1Addr = opAddr;
      nxt_wp1Mask = laneAct;
      nxt_wp2Valid = wp1Valid_ff;
      nxt_wp2Addr = wp1Addr_ff;
      nxt_wp2Mask = wp1Mask_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPend_ff <= 1'b0;
      drive_ff <= 1'b0;
      hitMask_ff <= '0;
      hitData_ff <= '0;
      outWord_ff <= '0;
      wp1Valid_ff <= 1'b0;
      wp2Valid_ff <= 1'b0;
      wp1Addr_ff <= '0;
      wp2Addr_ff <= '0;
      wp1Mask_ff <= '0;
      wp2Mask_ff <= '0;
    end else if (clkEn) begin
      rdPend_ff <= nxt_rdPend;
      drive_ff <= nxt_drive;
      hitMask_ff <= nxt_hitMask;
      hitData_ff <= nxt_hitData;
      outWord_ff <= nxt_outWord;
      wp1Valid_ff <= nxt_wp1Valid;
      wp2Valid_ff <= nxt_wp2Valid;
      wp1Addr_ff <= nxt_wp1Addr;
      wp2Addr_ff <= nxt_wp2Addr;
      wp1Mask_ff <= nxt_wp1Mask;
      wp2Mask_ff <= nxt_wp2Mask;
    end
  end

  // write data taken on the second qualified edge after the command
  assign pushValid = wp2Valid_ff & step;
  // a read of the head word holds it back; the lookup covers it
  assign drainReady = ~(opRead && opAddr == drainAddr);

  pbsc_skid #(
    .AW(ADDR_W),
    .LANES(LANES),
    .BYTE_W(BYTE_W)
  ) u_skid (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .inValid(pushValid),
    .inReady(writeQueueReady),
    .inAddr(wp2Addr_ff),
    .inData({parity_lines_in, dqIn}),
    .inMask(wp2Mask_ff),
    .outValid(drainValid),
    .outReady(drainReady),
    .outAddr(drainAddr),
    .outData(drainData),
    .outMask(drainMask),
    .lookAddr(opAddr),
    .hitMask(lookMask),
    .hitData(lookData)
  );

  pbsc_mem #(
    .AW(ADDR_W),
    .LANES(LANES),
    .BYTE_W(BYTE_W)
  ) u_mem (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .rdEn(opRead),
    .rdAddr(opAddr),
    .rdData(memRdData),
    .wrEn(drainValid & drainReady),
    .wrAddr(drainAddr),
    .wrData(drainData),
    .wrMask(drainMask)
  );

  // output enable is not sampled; only read beats ever drive
  assign dqOe = drive_ff & ~outputEnableN & ~sleepAct;
  assign parity_lines_oe = drive_ff & ~outputEnableN & ~sleepAct;
  assign dqOut = outWord_ff[DATA_W-1:0];
  assign parity_lines_out = outWord_ff[WORD_W-1:DATA_W];
  assign sleepState = sleepAct;

endmodule // pbsc_top

`default_nettype wire

//--- pbsc_top_properties.sv
/*
  Concurrent checks on the pins of pbsc_top, bound to every instance.
  Assumes one clock, sys_clk, and the asynchronous active-low rst_n.
*/
`include "pbsc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pbsc_chk #(
  parameter int ADDR_W = `PBSC_ADDR_W,
  parameter int LANES = `PBSC_LANES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic clock_qualify_n,
  input wire logic advance_or_load,
  input wire logic writeEnableN,
  input wire logic chip_select_1_n,
  input wire logic chip_select_2,
  input wire logic chip_select_3_n,
  input wire logic sleep_request,
  input wire logic outputEnableN,
  input wire logic [LANES*`PBSC_BYTE_W-1:0] dqOut,
  input wire logic dqOe,
  input wire logic parity_lines_oe,
  input wire logic writeQueueReady,
  input wire logic sleepState
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic qual;
  logic sel;
  logic load;
  assign qual = clkEn && !clock_qualify_n && !sleepState;
  assign sel = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  assign load = qual && !advance_or_load;

  a_sleep_quiet: assert property (sleepState |-> !dqOe)
    else $error("data driven while asleep");
  a_sleep_entry: assert property (
    (clkEn && sleep_request)[*2] |=> sleepState)
    else $error("sleep not entered in two clocks");
  a_oe_gates: assert property (dqOe |-> !outputEnableN)
    else $error("driving with output enable off");
  a_parity_follows: assert property (parity_lines_oe == dqOe)
    else $error("parity enable differs from data enable");
  a_deselect_off: assert property (load && !sel ##1 qual |=> !dqOe)
    else $error("bus driven after deselect");
  a_write_off: assert property (
    load && sel && !writeEnableN ##1 qual |=> !dqOe)
    else $error("bus driven during write");
  a_read_drives: assert property (
    load && sel && writeEnableN ##1 qual |=>
    dqOe == (!outputEnableN && !sleepState))
    else $error("read data not driven one edge later");
  a_stall_holds: assert property (
    clkEn && clock_qualify_n && !sleepState |=>
    $stable(dqOut) || sleepState)
    else $error("read data moved on an ignored edge");
  a_freeze_holds: assert property (
    !clkEn |=> $stable(dqOut) && $stable(sleepState))
    else $error("state moved while frozen");
  a_reset_clean: assert property (
    $rose(rst_n) |-> !dqOe && writeQueueReady)
    else $error("not quiet after reset");

  c_read: cover property (load && sel && writeEnableN ##2 dqOe);
  c_write: cover property (
    load && sel && !writeEnableN ##1 qual && advance_or_load);
  c_sleep: cover property ($rose(sleepState));
endmodule // pbsc_chk

bind pbsc_top pbsc_chk #(.ADDR_W(ADDR_W), .LANES(LANES)) i_pbsc_chk (
  .sys_clk, .rst_n, .clkEn, .clock_qualify_n, .advance_or_load, .writeEnableN,
  .chip_select_1_n, .chip_select_2, .chip_select_3_n, .sleep_request,
  .outputEnableN, .dqOut, .dqOe, .parity_lines_oe, .writeQueueReady,
  .sleepState
);
`default_nettype wire

//--- pbsc_ctrl_model.sv
/*
  Memory controller model: drives command pins one beat at a time and
  sends write data two qualified edges after each write beat.
  Assumes beat is called just after a rising edge of sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module pbsc_ctrl_model #(
  parameter int AW = 6
) (
  input wire logic sys_clk,
  input wire logic clkEn,
  input wire logic sleepState,
  output logic clock_qualify_n,
  output logic advance_or_load,
  output logic writeEnableN,
  output logic chip_select_1_n,
  output logic chip_select_2,
  output logic chip_select_3_n,
  output logic [3:0] byte_lane_write_n,
  output logic [AW-1:0] addrIn,
  output logic [31:0] dqIn,
  output logic [3:0] parity_lines_in
);
  logic [35:0] wData, p1, p2, lastBus;
  logic wVal, v1, v2;
  initial begin
    {clock_qualify_n, advance_or_load, writeEnableN} = 3'h1;
    {chip_select_1_n, chip_select_2, chip_select_3_n} = 3'h5;
    byte_lane_write_n = 4'hf;
    addrIn = '0;
    {wVal, v1, v2, wData, p1, p2, lastBus} = '0;
  end

  task automatic beat(input logic qn, input logic aol, input logic we,
    input logic sel, input logic [3:0] bw, input logic [AW-1:0] a,
    input logic wv, input logic [35:0] wd);
    clock_qualify_n = qn;
    advance_or_load = aol;
    writeEnableN = we;
    {chip_select_1_n, chip_select_2, chip_select_3_n} = sel ? 3'h2 : 3'h5;
    byte_lane_write_n = bw;
    addrIn = a;
    wVal = wv;
    wData = wd;
    @(posedge sys_clk);
    #1;
  endtask

  // write data follows its beat by two qualified edges
  always @(posedge sys_clk) begin
    if (sleepState) begin
      v1 <= #1 1'b0;
      v2 <= #1 1'b0;
    end else if (clkEn && !clock_qualify_n) begin
      v1 <= #1 wVal;
      p1 <= #1 wData;
      v2 <= #1 v1;
      p2 <= #1 p1;
      if (v2) lastBus <= #1 p2;
    end
  end
  // released bus shows the inverse of the last word
  assign {parity_lines_in, dqIn} = v2 ? p2 : ~lastBus;
endmodule // pbsc_ctrl_model
`default_nettype wire

//--- testbench.sv
/*
  Self-checking bench for pbsc_top with a controller model in front.
  Assumes the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  fail_count++; $display("ERROR %s exp %h got %h", n, e, g); end end

module testbench;
  logic sys_clk, rst_n, clkEn, burstOrder, sleep_request, outputEnableN;
  logic clock_qualify_n, advance_or_load, writeEnableN;
  logic chip_select_1_n, chip_select_2, chip_select_3_n;
  logic [3:0] byte_lane_write_n, parity_lines_in, parity_lines_out;
  logic [5:0] addrIn;
  logic [31:0] dqIn, dqOut;
  logic dqOe, parity_lines_oe, writeQueueReady, sleepState;
  wire [35:0] rdWord;
  logic [35:0] mem [0:63];
  int fail_count = 0;
  int check_count = 0;

  pbsc_top #(.ADDR_W(6), .LANES(4)) i_pbsc_top (.sys_clk, .rst_n, .clkEn,
    .clock_qualify_n, .advance_or_load, .writeEnableN, .chip_select_1_n,
    .chip_select_2, .chip_select_3_n, .byte_lane_write_n, .addrIn,
    .burstOrder, .sleep_request, .outputEnableN, .dqIn, .dqOut, .dqOe,
    .parity_lines_in, .parity_lines_out, .parity_lines_oe,
    .writeQueueReady, .sleepState);
  pbsc_ctrl_model #(.AW(6)) i_pbsc_ctrl_model (.sys_clk, .clkEn,
    .sleepState, .clock_qualify_n, .advance_or_load, .writeEnableN,
    .chip_select_1_n, .chip_select_2, .chip_select_3_n, .byte_lane_write_n,
    .addrIn, .dqIn, .parity_lines_in);
  assign rdWord = {parity_lines_out, dqOut};

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [5:0] nxt(logic [5:0] a, int k, logic il);
    logic [1:0] c;
    c = 2'(k);
    return {a[5:2], il ? a[1:0] ^ c : a[1:0] + c};
  endfunction

  task automatic idle(input int n);
    repeat (n) i_pbsc_ctrl_model.beat(0, 0, 1, 0, 4'hf, '0, 0, '0);
  endtask

  task automatic rd1(input logic [5:0] a);
    i_pbsc_ctrl_model.beat(0, 0, 1, 1, 4'hf, a, 0, '0);
    idle(1);
    `CHK("single read", mem[a], rdWord)
  endtask

  task automatic t_burst(input logic il, input logic [5:0] base);
    logic [35:0] d;
    logic [3:0] bw;
    logic [5:0] w;
    burstOrder = il;
    idle(3);
    for (int k = 0; k < 6; k++) begin
      d = {4'(k + 9), {4{8'(k * 17 + 1)}}};
      bw = (k < 4) ? 4'h0 : (k == 4) ? 4'hf : 4'ha;
      w = nxt(base, k, il);
      i_pbsc_ctrl_model.beat(0, k > 0, k > 0, k == 0, bw,
        (k > 0) ? ~base : base, 1, d);
      `CHK("write oe", 1'b0, dqOe)
      `CHK("queue ready", 1'b1, writeQueueReady)
      for (int i = 0; i < 4; i++) if (!bw[i]) begin
        mem[w][8*i+:8] = d[8*i+:8];
        mem[w][32+i] = d[32+i];
      end
    end
    idle(2);
    rd1(nxt(base, 1, il));
    i_pbsc_ctrl_model.beat(0, 0, 1, 1, 4'hf, base, 0, '0);
    for (int k = 0; k < 5; k++) begin
      i_pbsc_ctrl_model.beat(0, 1, 0, 0, 4'h0, ~base, 0, '0);
      `CHK("burst data", mem[nxt(base, k, il)], rdWord)
      `CHK("burst oe", 1'b1, dqOe)
    end
    idle(2);
    i_pbsc_ctrl_model.beat(0, 1, 1, 1, 4'hf, base, 0, '0);
    `CHK("deselect oe", 1'b0, dqOe)
    $display("test burst order %0d done", il);
  endtask

  task automatic t_dummy(input logic [5:0] base);
    outputEnableN = 1'b1;
    i_pbsc_ctrl_model.beat(0, 0, 1, 1, 4'hf, base, 0, '0);
    i_pbsc_ctrl_model.beat(0, 1, 1, 1, 4'hf, base, 0, '0);
    `CHK("dummy oe", 1'b0, dqOe)
    outputEnableN = 1'b0;
    #1;
    `CHK("async oe", 1'b1, dqOe)
    `CHK("dummy data", mem[base], rdWord)
    i_pbsc_ctrl_model.beat(0, 1, 1, 1, 4'hf, base, 0, '0);
    `CHK("dummy next", mem[nxt(base, 1, burstOrder)], rdWord)
    idle(2);
    $display("test dummy done");
  endtask

  task automatic t_stall(input logic [5:0] base);
    i_pbsc_ctrl_model.beat(0, 0, 1, 1, 4'hf, base, 0, '0);
    repeat (2) i_pbsc_ctrl_model.beat(1, 0, 1, 0, 4'hf, ~base, 0, '0);
    clkEn = 1'b0;
    i_pbsc_ctrl_model.beat(0, 1, 1, 1, 4'hf, base, 0, '0);
    clkEn = 1'b1;
    `CHK("stall oe", 1'b0, dqOe)
    i_pbsc_ctrl_model.beat(0, 1, 1, 1, 4'hf, base, 0, '0);
    `CHK("stall data", mem[base], rdWord)
    idle(2);
    $display("test stall done");
  endtask

  task automatic t_sleep(input logic [5:0] base);
    idle(1);
    sleep_request = 1'b1;
    idle(2);
    `CHK("asleep", 1'b1, sleepState)
    i_pbsc_ctrl_model.beat(0, 0, 1, 1, 4'hf, base, 0, '0);
    idle(1);
    `CHK("sleep oe", 1'b0, dqOe)
    sleep_request = 1'b0;
    idle(4);
    `CHK("awake", 1'b0, sleepState)
    rd1(base);
    $display("test sleep done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    end_of_test;
  end

  initial begin
    // output enable active through reset: the bus must still stay off
    {rst_n, clkEn, burstOrder, sleep_request, outputEnableN} = 5'h0c;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    `CHK("reset oe", 1'b0, dqOe)
    `CHK("reset sleep", 1'b0, sleepState)
    outputEnableN = 1'b0;
    t_burst(1'b1, 6'h01);
    t_burst(1'b0, 6'h17);
    t_dummy(6'h01);
    t_stall(6'h17);
    t_sleep(6'h14);
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
